// ### dv/pifs_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side of the register port
module pifs_host_model (
	input  wire logic       clock,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata
);
	logic [7:0] exp_q[$];
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// One-cycle write strobe; released data flips so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// Expected read data is noted as the strobe goes out
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule // pifs_host_model

// ### dv/pifs_irq_flags_tb.sv
`timescale 1ns/1ps
module pifs_irq_flags_tb
	import pifs_pkg::*;
;
	logic       clock;
	logic       rst;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] rdata;
	logic [7:0] power_events;
	logic [3:0] sup;
	logic       sleep;
	logic       irq;
	logic       rd_seen;
	logic [7:0] v;
	int         seed;
	int         failures = 0;
	int         n_tests = 0;
	// ==========================================================
	// Instances
	pifs_irq_flags u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(rdata),
		.power_events(power_events), .pushbutton_reset_input(~sup[3]),
		.watchdog_alarm(sup[2]), .step_down_rail_good(sup[1]),
		.up_down_rail_good(sup[0]), .transport_sleep_request_q(sleep), .irq_q(irq));
	pifs_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata));
	// ==========================================================
	// Checking
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t value %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Read data lands one edge after the strobe; oldest note is compared
	always @(posedge clock) rd_seen <= reg_rd;
	always @(negedge clock) begin
		if (rd_seen === 1'b1) chk(rdata, u_host.exp_q.pop_front());
	end
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Hang guard
	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		give_verdict();
	end
	// ==========================================================
	// Scenarios
	initial begin
		seed = 25260;
		rst = 1'b1;
		power_events = 8'h00;
		sup = 4'h0;
		repeat (6) @(posedge clock);
		@(negedge clock) rst = 1'b0;
		// Everything reads zero after reset, unmapped place too
		for (logic [7:0] a = 8'h32; a < 8'h38; a++) u_host.rd(a, 8'h00);
		u_host.wr(PIFS_ADDR_SUPV_FLAGS, 8'hFF);
		u_host.rd(PIFS_ADDR_SUPV_FLAGS, 8'h00);
		u_host.wr(PIFS_ADDR_TRANSPORT_SLEEP, 8'hFF);
		u_host.rd(PIFS_ADDR_TRANSPORT_SLEEP, 8'h01);
		chk({7'h00, sleep}, 8'h01);
		u_host.wr(PIFS_ADDR_TRANSPORT_SLEEP, 8'h00);
		chk({7'h00, sleep}, 8'h00);
		// One source at a time; second read proves clear-on-read
		for (int i = 0; i < 4; i++) begin
			@(negedge clock) sup[3-i] = 1'b1;
			u_host.rd(PIFS_ADDR_SUPV_FLAGS, 8'h80 >> i);
			u_host.rd(PIFS_ADDR_SUPV_FLAGS, 8'h00);
		end
		// Release: only the rail flags see either edge
		@(negedge clock) sup = 4'h0;
		u_host.rd(PIFS_ADDR_SUPV_FLAGS, 8'h30);
		// Only the allowed flag drives the interrupt, and it stays latched
		u_host.wr(PIFS_ADDR_SUPV_IRQ_ALLOW, 8'h80);
		u_host.rd(PIFS_ADDR_SUPV_IRQ_ALLOW, 8'h80);
		@(negedge clock) sup[2] = 1'b1;
		repeat (2) @(negedge clock);
		chk({7'h00, irq}, 8'h00);
		sup[3] = 1'b1;
		repeat (3) @(negedge clock);
		sup[3] = 1'b0;
		repeat (2) @(negedge clock);
		chk({7'h00, irq}, 8'h01);
		u_host.rd(PIFS_ADDR_SUPV_FLAGS, 8'hC0);
		repeat (2) @(negedge clock);
		chk({7'h00, irq}, 8'h00);
		// Random power events with all power allows set
		u_host.wr(PIFS_ADDR_POWER_IRQ_ALLOW, 8'hFF);
		repeat (4) begin
			v = 8'($random(seed));
			@(negedge clock) power_events = v;
			repeat (2) @(negedge clock);
			chk({7'h00, irq}, {7'h00, |v});
			u_host.rd(PIFS_ADDR_POWER_FLAGS, v);
			@(negedge clock) power_events = 8'h00;
		end
		// An event in the read cycle survives the clear; allows gate per bit
		u_host.wr(PIFS_ADDR_POWER_IRQ_ALLOW, 8'h0A);
		u_host.rd(PIFS_ADDR_POWER_IRQ_ALLOW, 8'h0A);
		fork
			u_host.rd(PIFS_ADDR_POWER_FLAGS, 8'h00);
			@(negedge clock) power_events = 8'h05;
		join
		repeat (2) @(negedge clock);
		chk({7'h00, irq}, 8'h00);
		power_events = 8'h0F;
		repeat (2) @(negedge clock);
		chk({7'h00, irq}, 8'h01);
		u_host.rd(PIFS_ADDR_POWER_FLAGS, 8'h0F);
		@(negedge clock) power_events = 8'h00;
		repeat (3) @(negedge clock);
		give_verdict();
	end
endmodule // pifs_irq_flags_tb

// ### hdl/pifs_event_latch.sv
`timescale 1ns/1ps
// Sticky event flag: set wins over clear-on-read
module pifs_event_latch (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic set_pulse,
	input  wire logic clear_pulse,
	output logic      flag_q
);
	// ==========================================================
	// Latch
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (set_pulse) begin
			flag_q <= 1'b1;
		end else if (clear_pulse) begin
			flag_q <= 1'b0;
		end
	end
endmodule // pifs_event_latch

// ### hdl/pifs_irq_flags.sv
`timescale 1ns/1ps
// Behaviour
// - Pushbutton reset press sets flag bit seven
// - Watchdog alarm sets flag bit six
// - Step-down rail good change sets bit five
// - Up-down rail good change sets bit four
// - Reading a flag register clears read flags
// - Bit zero controls transport sleep, resets zero
// - Supervisor flags gated by allow bits 7:4
// - Power flag register reports eight events
// - Power allow bits align, reset zero
module pifs_irq_flags
	import pifs_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata_q,
	input  wire logic [7:0] power_events,
	input  wire logic       pushbutton_reset_input,
	input  wire logic       watchdog_alarm,
	input  wire logic       step_down_rail_good,
	input  wire logic       up_down_rail_good,
	output logic            transport_sleep_request_q,
	output logic            irq_q
);
	// ==========================================================
	// Event detection
	logic       step_down_seen_q;
	logic       up_down_seen_q;
	logic       pushbutton_seen_q;
	logic       watchdog_seen_q;
	logic [7:0] power_seen_q;
	logic [7:0] power_flags;
	logic [7:0] supv_flags;
	logic [7:0] power_allow_q;
	logic [7:0] supv_allow_q;
	logic [7:0] power_set;
	logic [7:0] supv_set;
	wire  sel_pallow = (reg_addr == PIFS_ADDR_POWER_IRQ_ALLOW);
	wire  sel_sallow = (reg_addr == PIFS_ADDR_SUPV_IRQ_ALLOW);
	wire  sel_pflags = (reg_addr == PIFS_ADDR_POWER_FLAGS);
	wire  sel_sflags = (reg_addr == PIFS_ADDR_SUPV_FLAGS);
	wire  sel_sleep  = (reg_addr == PIFS_ADDR_TRANSPORT_SLEEP);
	wire  rd_pflags  = reg_rd && sel_pflags;
	wire  rd_sflags  = reg_rd && sel_sflags;

	// Pushbutton is active low on the pin; press is the falling edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pushbutton_seen_q <= 1'b1;
			watchdog_seen_q   <= 1'b0;
			step_down_seen_q  <= 1'b0;
			up_down_seen_q    <= 1'b0;
			power_seen_q      <= PIFS_RESET_BYTE;
		end else begin
			pushbutton_seen_q <= pushbutton_reset_input;
			watchdog_seen_q   <= watchdog_alarm;
			step_down_seen_q  <= step_down_rail_good;
			up_down_seen_q    <= up_down_rail_good;
			power_seen_q      <= power_events;
		end
	end

	// Edges form one-cycle set pulses; rail good flags fire on either change
	always_comb begin
		supv_set = PIFS_RESET_BYTE;
		supv_set[PIFS_BIT_PUSHBUTTON] = pushbutton_seen_q && !pushbutton_reset_input;
		supv_set[PIFS_BIT_WATCHDOG]   = watchdog_alarm && !watchdog_seen_q;
		supv_set[PIFS_BIT_STEP_DOWN]  = step_down_rail_good ^ step_down_seen_q;
		supv_set[PIFS_BIT_UP_DOWN]    = up_down_rail_good ^ up_down_seen_q;
	end
	assign power_set = power_events & ~power_seen_q;

	// ==========================================================
	// Sticky flags, one latch per bit; reserved bits stay zero
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			pifs_event_latch u_power (
				.clock       (clock),
				.rst         (rst),
				.set_pulse   (power_set[gi]),
				.clear_pulse (rd_pflags),
				.flag_q      (power_flags[gi])
			);
			if (PIFS_SUPV_MASK[gi]) begin : g_supv
				pifs_event_latch u_supv (
					.clock       (clock),
					.rst         (rst),
					.set_pulse   (supv_set[gi]),
					.clear_pulse (rd_sflags),
					.flag_q      (supv_flags[gi])
				);
			end else begin : g_rsvd
				assign supv_flags[gi] = 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// Writable registers; reserved allow bits 3:0 kept as storage
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			power_allow_q             <= PIFS_RESET_BYTE;
			supv_allow_q              <= PIFS_RESET_BYTE;
			transport_sleep_request_q <= 1'b0;
		end else if (reg_wr) begin
			if (sel_pallow) begin
				power_allow_q <= reg_wdata;
			end else if (sel_sallow) begin
				supv_allow_q <= reg_wdata;
			end else if (sel_sleep) begin
				transport_sleep_request_q <= reg_wdata[PIFS_BIT_SLEEP_REQ];
			end
		end
	end

	// ==========================================================
	// Read mux; unmapped addresses return zero
	logic [7:0] rdata_d;
	assign rdata_d = sel_pallow ? power_allow_q :
		sel_sallow ? supv_allow_q :
		sel_pflags ? power_flags :
		sel_sflags ? supv_flags :
		sel_sleep ? ({7'h00, transport_sleep_request_q} & PIFS_SLEEP_MASK) :
		PIFS_RESET_BYTE;

	// Only allowed power and supervisor bits count; reserved allow bits are ignored
	wire irq_d = |(power_flags & power_allow_q) |
		|(supv_flags & supv_allow_q & PIFS_SUPV_MASK);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= PIFS_RESET_BYTE;
			irq_q       <= 1'b0;
		end else begin
			reg_rdata_q <= reg_rd ? rdata_d : reg_rdata_q;
			irq_q       <= irq_d;
		end
	end

	// ==========================================================
	// Checks
	sequence s_rd_sflags;
		rd_sflags && !(|supv_set);
	endsequence
	property p_clear_on_read;
		@(posedge clock) disable iff (rst) s_rd_sflags |=> (supv_flags == PIFS_RESET_BYTE);
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("flags not cleared");
	property p_mr_set;
		@(posedge clock) disable iff (rst)
			$fell(pushbutton_reset_input) |=> supv_flags[PIFS_BIT_PUSHBUTTON];
	endproperty
	a_mr_set: assert property (p_mr_set) else $error("press flag missing");
	property p_wd_set;
		@(posedge clock) disable iff (rst) $rose(watchdog_alarm) |=> supv_flags[PIFS_BIT_WATCHDOG];
	endproperty
	a_wd_set: assert property (p_wd_set) else $error("watchdog flag missing");
	property p_sd_set;
		@(posedge clock) disable iff (rst)
			$changed(step_down_rail_good) |=> supv_flags[PIFS_BIT_STEP_DOWN];
	endproperty
	a_sd_set: assert property (p_sd_set) else $error("step-down flag missing");
	property p_ud_set;
		@(posedge clock) disable iff (rst)
			$changed(up_down_rail_good) |=> supv_flags[PIFS_BIT_UP_DOWN];
	endproperty
	a_ud_set: assert property (p_ud_set) else $error("up-down flag missing");
	property p_rsvd;
		@(posedge clock) disable iff (rst) (supv_flags & ~PIFS_SUPV_MASK) == PIFS_RESET_BYTE;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved flag set");
	property p_sleep;
		@(posedge clock) disable iff (rst)
			(reg_wr && sel_sleep) |=> transport_sleep_request_q == $past(reg_wdata[PIFS_BIT_SLEEP_REQ]);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep bit wrong");
	property p_irq;
		@(posedge clock) disable iff (rst) (|(supv_flags & supv_allow_q & PIFS_SUPV_MASK)) |=> irq_q;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	property p_power;
		@(posedge clock) disable iff (rst)
			(power_set[3] && !rd_pflags) |=> power_flags[3] [*1] ##1 (power_flags[3] || $past(rd_pflags));
	endproperty
	a_power: assert property (p_power) else $error("power flag not latched");
	property p_quiet;
		@(posedge clock) disable iff (rst) ((power_allow_q | supv_allow_q) == PIFS_RESET_BYTE) |=> !irq_q;
	endproperty
	a_quiet: assert property (p_quiet) else $error("irq while all masked");
	// Set wins over clear-on-read: after a read only the events of that cycle remain
	sequence s_rd_pflags;
		rd_pflags;
	endsequence
	property p_power_clr;
		@(posedge clock) disable iff (rst)
			s_rd_pflags |=> (power_flags == $past(power_set));
	endproperty
	a_power_clr: assert property (p_power_clr) else $error("power flags kept");
	sequence s_rd_sflags_hit;
		rd_sflags && (|supv_set);
	endsequence
	property p_supv_wins;
		@(posedge clock) disable iff (rst)
			s_rd_sflags_hit |=> (supv_flags == $past(supv_set));
	endproperty
	a_supv_wins: assert property (p_supv_wins) else $error("event lost in read");
	// Read data stands until the next read and carries the flags of the read edge
	property p_rdata_hold;
		@(posedge clock) disable iff (rst) !reg_rd |=> $stable(reg_rdata_q);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_rdata_flags;
		@(posedge clock) disable iff (rst) rd_sflags |=> (reg_rdata_q == $past(supv_flags));
	endproperty
	a_rdata_flags: assert property (p_rdata_flags) else $error("flag read wrong");
	property p_sleep_rsvd;
		@(posedge clock) disable iff (rst)
			(reg_rd && sel_sleep) |=> ((reg_rdata_q & ~PIFS_SLEEP_MASK) == PIFS_RESET_BYTE);
	endproperty
	a_sleep_rsvd: assert property (p_sleep_rsvd) else $error("sleep reserved set");
	property p_power_irq;
		@(posedge clock) disable iff (rst) (|(power_flags & power_allow_q)) |=> irq_q;
	endproperty
	a_power_irq: assert property (p_power_irq) else $error("power irq missing");
endmodule // pifs_irq_flags

// ### inc/pifs_pkg.sv
package pifs_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] PIFS_ADDR_POWER_IRQ_ALLOW = 8'h32;
	localparam logic [7:0] PIFS_ADDR_SUPV_IRQ_ALLOW  = 8'h33;
	localparam logic [7:0] PIFS_ADDR_POWER_FLAGS     = 8'h34;
	localparam logic [7:0] PIFS_ADDR_SUPV_FLAGS      = 8'h35;
	localparam logic [7:0] PIFS_ADDR_TRANSPORT_SLEEP = 8'h36;
	// ==========================================================
	// Field layout
	localparam int PIFS_BIT_PUSHBUTTON = 7;
	localparam int PIFS_BIT_WATCHDOG   = 6;
	localparam int PIFS_BIT_STEP_DOWN  = 5;
	localparam int PIFS_BIT_UP_DOWN    = 4;
	localparam int PIFS_BIT_SLEEP_REQ  = 0;
	localparam logic [7:0] PIFS_SUPV_MASK  = 8'hF0;
	localparam logic [7:0] PIFS_SLEEP_MASK = 8'h01;
	localparam logic [7:0] PIFS_RESET_BYTE = 8'h00;
endpackage
